// File: verilog/rsss_exec.sv
// Function
// - Rotate right through carry: working gets carry and mem[7:1], carry gets mem[0].
// - Rotate right to working never writes the memory byte.
// - Subtract with borrow to working: working minus memory minus inverted carry.
// - Subtract with borrow to memory: same difference written to the memory byte.
// - Subtract carry is 0 on negative result, 1 on zero or positive.
// - Subtracts update wrap, zero, half carry, carry, chained sign, chained zero.
// - Decrement skip: memory minus one written back, skip when zero.
// - A skip inserts one dummy slot that waits for a valid word, making the instruction at least three cycles.
// - Nonzero decrement or increment result continues with the next instruction.
// - Decrement skip to working: working gets memory minus one, memory kept.
// - Set ones writes all ones to memory, flags unchanged.
// - Set bit forces selected bit to one, others and flags kept.
// - Increment skip: memory plus one written back, skip when it wraps to zero.
// - Increment skip to working: working gets memory plus one, skip on zero.
module rsss_exec
   import rsss_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   // Instruction issue from the sequencer
   input  wire rsss_req_t    req_i,
   output logic              ready_o,
   // Data memory write port
   output rsss_mem_wr_t      mem_wr_o,
   // Architectural state and sequencer feedback
   output logic [DATA_W-1:0] working_register_o,
   output rsss_flags_t       flags_o,
   output logic              skip_o,
   output logic              squash_o,
   output logic              done_o
);

   // ****************************************
   // Helpers
   // ****************************************
   // Zero test shared by the subtract flags and every skip decision
   function automatic logic is_zero(input logic [DATA_W-1:0] v);
      is_zero = (v == ZERO_BYTE);
   endfunction : is_zero

   // ****************************************
   // State
   // ****************************************
   rsss_state_t       state_ff,   nxt_state;
   logic [DATA_W-1:0] work_ff,    nxt_work;
   rsss_flags_t       flags_ff,   nxt_flags;
   rsss_mem_wr_t      wr_ff,      nxt_wr;
   logic              skip_ff,    nxt_skip;
   logic              done_ff,    nxt_done;

   logic [DATA_W-1:0] sub_diff;
   logic              sub_carry;
   logic              sub_half;
   logic              sub_wrap;
   logic [DATA_W-1:0] dec_val;
   logic [DATA_W-1:0] inc_val;
   logic              take;

   rsss_sub_unit u_sub (
      .minuend_i    (work_ff),
      .subtrahend_i (req_i.mem_data),
      .carry_i      (flags_ff.carry),
      .diff_o       (sub_diff),
      .carry_o      (sub_carry),
      .half_carry_o (sub_half),
      .wrap_o       (sub_wrap)
   );

   // ****************************************
   // Sequencer: take, execute, dummy slot
   // ****************************************
   always_comb begin
      // Busy only in EXEC; DUMMY consumes and drops the fetched instruction
      ready_o   = (state_ff != ST_EXEC);
      // Take is shared with the datapath so both groups see the same edge
      take      = req_i.valid && (state_ff == ST_IDLE);
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (take) begin
               nxt_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            // Skip is decided in the taking cycle, which keeps the compare off this path
            nxt_state = skip_ff ? ST_DUMMY : ST_IDLE;
         end
         ST_DUMMY: begin
            // The instruction fetched here is swallowed without any write; the slot
            // waits for it, since an empty fetch cycle is not the skipped instruction
            if (req_i.valid) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            // A corrupted state code falls back to idle
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************
   // Datapath: results of the taken instruction
   // ****************************************
   always_comb begin
      dec_val   = req_i.mem_data - ONE_BYTE;
      inc_val   = req_i.mem_data + ONE_BYTE;
      nxt_work  = work_ff;
      nxt_flags = flags_ff;
      nxt_wr    = MEM_WR_RST;
      nxt_skip  = 1'b0;
      nxt_done  = 1'b0;
      // Results are formed only in the taking cycle
      case (state_ff)
         ST_IDLE: begin
            if (take) begin
               nxt_done    = 1'b1;
               nxt_wr.addr = req_i.addr;
               case (req_i.op)
                  OP_ROTATE_RIGHT_CARRY: begin
                     nxt_work        = {flags_ff.carry, req_i.mem_data[7:1]};
                     nxt_flags.carry = req_i.mem_data[0];
                     nxt_wr.en       = 1'b0;
                  end
                  OP_SUBTRACT_BORROW_W, OP_SUBTRACT_BORROW_M: begin
                     if (req_i.op == OP_SUBTRACT_BORROW_W) begin
                        nxt_work = sub_diff;
                     end else begin
                        nxt_wr.en   = 1'b1;
                        nxt_wr.data = sub_diff;
                     end
                     nxt_flags.carry             = sub_carry;
                     nxt_flags.signed_wrap_flag  = sub_wrap;
                     nxt_flags.zero              = is_zero(sub_diff);
                     nxt_flags.half_carry_flag   = sub_half;
                     nxt_flags.chained_sign_flag = sub_diff[7] ^ sub_wrap;
                     // Chained zero holds only while every chained byte was zero
                     nxt_flags.chained_zero_flag = is_zero(sub_diff)
                                                   & flags_ff.chained_zero_flag;
                  end
                  OP_DECREMENT_SKIP_M: begin
                     nxt_wr.en   = 1'b1;
                     nxt_wr.data = dec_val;
                     nxt_skip    = is_zero(dec_val);
                  end
                  OP_DECREMENT_SKIP_W: begin
                     nxt_work = dec_val;
                     nxt_skip = is_zero(dec_val);
                  end
                  OP_SET_MEMORY_ONES: begin
                     nxt_wr.en   = 1'b1;
                     nxt_wr.data = ALL_ONES;
                  end
                  OP_SET_MEMORY_BIT: begin
                     nxt_wr.en                   = 1'b1;
                     nxt_wr.data                 = req_i.mem_data;
                     nxt_wr.data[req_i.bit_sel]  = 1'b1;
                  end
                  OP_INCREMENT_SKIP_M: begin
                     nxt_wr.en   = 1'b1;
                     nxt_wr.data = inc_val;
                     nxt_skip    = is_zero(inc_val);
                  end
                  OP_INCREMENT_SKIP_W: begin
                     nxt_work = inc_val;
                     nxt_skip = is_zero(inc_val);
                  end
                  default: begin
                     // Unknown codes retire with no effect
                     nxt_wr.en = 1'b0;
                  end
               endcase
            end
         end
         default: begin
            // EXEC and DUMMY hold working and flags; write port, skip and done return to idle
            nxt_wr = MEM_WR_RST;
         end
      endcase
   end

   // ****************************************
   // Registers
   // ****************************************
   // Write port, skip and done default to idle, so each is a single-cycle pulse
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         work_ff  <= WORK_RST;
         flags_ff <= FLAGS_RST;
         wr_ff    <= MEM_WR_RST;
         skip_ff  <= 1'b0;
         done_ff  <= 1'b0;
      end else begin
         work_ff  <= nxt_work;
         flags_ff <= nxt_flags;
         wr_ff    <= nxt_wr;
         skip_ff  <= nxt_skip;
         done_ff  <= nxt_done;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign mem_wr_o           = wr_ff;
   assign working_register_o = work_ff;
   assign flags_o            = flags_ff;
   assign skip_o             = skip_ff;
   assign done_o             = done_ff;
   // Combinational so the fetch side can drop the word in the same cycle
   assign squash_o           = (state_ff == ST_DUMMY) && req_i.valid;

endmodule : rsss_exec

// File: verilog/rsss_pkg.sv
package rsss_pkg;

   // ****************************************
   // Widths and constants
   // ****************************************
   localparam int unsigned DATA_W    = 8;
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned BITSEL_W  = 3;
   localparam logic [7:0]  ALL_ONES  = 8'hFF;
   localparam logic [7:0]  ONE_BYTE  = 8'h01;
   localparam logic [7:0]  ZERO_BYTE = 8'h00;
   localparam logic [7:0]  WORK_RST  = 8'h00;

   // ****************************************
   // Operation codes
   // ****************************************
   typedef enum logic [3:0] {
      OP_NONE                = 4'h0,
      OP_ROTATE_RIGHT_CARRY  = 4'h1,
      OP_SUBTRACT_BORROW_W   = 4'h2,
      OP_SUBTRACT_BORROW_M   = 4'h3,
      OP_DECREMENT_SKIP_M    = 4'h4,
      OP_DECREMENT_SKIP_W    = 4'h5,
      OP_SET_MEMORY_ONES     = 4'h6,
      OP_SET_MEMORY_BIT      = 4'h7,
      OP_INCREMENT_SKIP_M    = 4'h8,
      OP_INCREMENT_SKIP_W    = 4'h9
   } rsss_op_t;

   // ****************************************
   // Sequencer states, one-hot
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_EXEC  = 3'h2,
      ST_DUMMY = 3'h4
   } rsss_state_t;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic                valid;
      rsss_op_t            op;
      logic [BITSEL_W-1:0] bit_sel;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   mem_data;
   } rsss_req_t;

   typedef struct packed {
      logic carry;
      logic signed_wrap_flag;
      logic zero;
      logic half_carry_flag;
      logic chained_sign_flag;
      logic chained_zero_flag;
   } rsss_flags_t;

   localparam rsss_flags_t FLAGS_RST = 6'h00;

   typedef struct packed {
      logic              en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } rsss_mem_wr_t;

   localparam rsss_mem_wr_t MEM_WR_RST = 17'h00000;

endpackage : rsss_pkg

// File: verilog/rsss_sub_unit.sv
module rsss_sub_unit
   import rsss_pkg::*;
(
   // Operands
   input  wire logic [DATA_W-1:0] minuend_i,
   input  wire logic [DATA_W-1:0] subtrahend_i,
   input  wire logic              carry_i,
   // Results
   output logic      [DATA_W-1:0] diff_o,
   output logic                   carry_o,
   output logic                   half_carry_o,
   output logic                   wrap_o
);

   logic [DATA_W:0] wide;
   logic [4:0]      low;

   always_comb begin
      // Borrow in is the complement of carry
      wide         = {1'b0, minuend_i} - {1'b0, subtrahend_i} - {8'h00, ~carry_i};
      low          = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]} - {4'h0, ~carry_i};
      diff_o       = wide[DATA_W-1:0];
      // Carry means no borrow: result was zero or positive
      carry_o      = ~wide[DATA_W];
      half_carry_o = ~low[4];
      wrap_o       = (minuend_i[7] != subtrahend_i[7]) && (wide[7] != minuend_i[7]);
   end

endmodule : rsss_sub_unit

// File: verif/rsss_asserts.sv
module rsss_asserts
   import rsss_pkg::*;
(
   // Clock and issue
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   input  wire rsss_req_t         req_i,
   input  wire logic              ready_o,
   // Results
   input  wire rsss_mem_wr_t      mem_wr_o,
   input  wire logic [DATA_W-1:0] working_register_o,
   input  wire rsss_flags_t       flags_o,
   input  wire logic              skip_o,
   input  wire logic              squash_o,
   input  wire logic              done_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // Squash also shows ready, so a consumed skip slot is no take
   logic take;
   assign take = ready_o && req_i.valid && !squash_o;
   property p_done; take |=> done_o; endproperty
   a_done: assert property (p_done) else $error("done missing");
   property p_skip; skip_o |=> ready_o && !done_o && !mem_wr_o.en; endproperty
   a_skip: assert property (p_skip) else $error("no dummy slot");
   property p_sq;
      squash_o |=> !done_o && !mem_wr_o.en && $stable(working_register_o) && $stable(flags_o);
   endproperty
   a_sq: assert property (p_sq) else $error("squash had effect");
   property p_rot;
      take && req_i.op == OP_ROTATE_RIGHT_CARRY |=> !mem_wr_o.en
         && working_register_o == {$past(flags_o.carry), $past(req_i.mem_data[7:1])}
         && flags_o.carry == $past(req_i.mem_data[0]);
   endproperty
   a_rot: assert property (p_rot) else $error("rotate wrong");
   property p_ones;
      take && req_i.op == OP_SET_MEMORY_ONES |=> mem_wr_o.en && mem_wr_o.data == ALL_ONES
         && mem_wr_o.addr == $past(req_i.addr) && $stable(flags_o);
   endproperty
   a_ones: assert property (p_ones) else $error("set ones wrong");
   property p_dec;
      take && req_i.op == OP_DECREMENT_SKIP_M |=> mem_wr_o.en
         && mem_wr_o.data == $past(req_i.mem_data) - ONE_BYTE
         && skip_o == (mem_wr_o.data == ZERO_BYTE);
   endproperty
   a_dec: assert property (p_dec) else $error("decrement wrong");
   property p_incw;
      take && req_i.op == OP_INCREMENT_SKIP_W |=> !mem_wr_o.en
         && working_register_o == $past(req_i.mem_data) + ONE_BYTE
         && skip_o == (working_register_o == ZERO_BYTE);
   endproperty
   a_incw: assert property (p_incw) else $error("increment wrong");
   property p_subc;
      take && req_i.op == OP_SUBTRACT_BORROW_W |=> flags_o.carry == ({1'b0,
         $past(working_register_o)} >= {1'b0, $past(req_i.mem_data)} + 9'($past(!flags_o.carry)));
   endproperty
   a_subc: assert property (p_subc) else $error("borrow wrong");
   c_skip: cover property (skip_o);
   c_sq: cover property (squash_o);
   c_subm: cover property (take && req_i.op == OP_SUBTRACT_BORROW_M);
endmodule : rsss_asserts

bind rsss_exec rsss_asserts i_rsss_asserts (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i),
   .ready_o(ready_o), .mem_wr_o(mem_wr_o), .working_register_o(working_register_o),
   .flags_o(flags_o), .skip_o(skip_o), .squash_o(squash_o), .done_o(done_o));

// File: verif/rsss_mem_model.sv
module rsss_mem_model
   import rsss_pkg::*;
(
   // Write side
   input  wire logic              clk_i,
   input  wire rsss_mem_wr_t      wr_i,
   // Read side, always shows the addressed byte
   input  wire logic [ADDR_W-1:0] addr_i,
   output logic      [DATA_W-1:0] data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem_ff [256];
   // Low bytes start at FE, FF, 00, 01 so wraps happen early
   initial for (int i = 0; i < 256; i++) mem_ff[i] = 8'(i - 2);
   always @(posedge clk_i) if (wr_i.en) mem_ff[wr_i.addr] <= wr_i.data;
   assign data_o = mem_ff[addr_i];
endmodule : rsss_mem_model

// File: verif/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rsss_pkg::*;
   logic         clk_i = 1'b0;
   logic         reset_i = 1'b1;
   logic         v;
   rsss_op_t     op;
   logic [2:0]   bs;
   logic [7:0]   ad, md, wr, rw;
   rsss_req_t    req_i;
   rsss_mem_wr_t mw;
   rsss_flags_t  fl;
   logic         rdy, sk_o, sq, dn, rc, rz, rv, rh, rs, rcz;
   logic [7:0]   rm [256];
   logic [31:0]  seed = 32'h000111EA;
   int           num_errors = 0;
   int           checks_done = 0;
   assign req_i = {v, op, bs, ad, md};
   rsss_exec i_rsss_exec (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .ready_o(rdy),
      .mem_wr_o(mw), .working_register_o(wr), .flags_o(fl), .skip_o(sk_o), .squash_o(sq),
      .done_o(dn));
   rsss_mem_model i_rsss_mem_model (.clk_i(clk_i), .wr_i(mw), .addr_i(ad), .data_o(md));
   initial forever #4 clk_i = ~clk_i;
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task give_verdict();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   task run(input rsss_op_t o, input logic [7:0] a, input logic [2:0] b);
      int d, h, s;
      logic [7:0] m;
      logic sk;
      op = o;
      ad = a;
      bs = b;
      v = 1'b1;
      m = rm[a];
      sk = 1'b0;
      case (o)
         OP_ROTATE_RIGHT_CARRY: begin
            rw = {rc, m[7:1]};
            rc = m[0];
         end
         OP_SUBTRACT_BORROW_W, OP_SUBTRACT_BORROW_M: begin
            d = int'(rw) - int'(m) - (rc ? 0 : 1);
            h = int'(rw[3:0]) - int'(m[3:0]) - (rc ? 0 : 1);
            s = int'($signed(rw)) - int'($signed(m)) - (rc ? 0 : 1);
            rc = d >= 0;
            rz = d[7:0] == 8'h00;
            rv = s < -128 || s > 127;
            rh = h >= 0;
            rs = s < 0;
            rcz = rz && rcz;
            if (o == OP_SUBTRACT_BORROW_W) rw = d[7:0];
            else rm[a] = d[7:0];
         end
         OP_DECREMENT_SKIP_M: rm[a] = m - 8'h01;
         OP_DECREMENT_SKIP_W: rw = m - 8'h01;
         OP_SET_MEMORY_ONES: rm[a] = 8'hFF;
         OP_SET_MEMORY_BIT: rm[a][b] = 1'b1;
         OP_INCREMENT_SKIP_M: rm[a] = m + 8'h01;
         OP_INCREMENT_SKIP_W: rw = m + 8'h01;
         default: ;
      endcase
      if (o inside {OP_DECREMENT_SKIP_M, OP_INCREMENT_SKIP_M}) sk = rm[a] == 8'h00;
      if (o inside {OP_DECREMENT_SKIP_W, OP_INCREMENT_SKIP_W}) sk = rw == 8'h00;
      @(posedge clk_i);
      #1;
      // A skip offers the next instruction at once; it must be swallowed
      v = sk;
      op = rsss_op_t'(4'(rnd() % 9 + 1));
      ad = 8'(rnd() % 4);
      chk("done", 8'h01, {7'h00, dn});
      chk("skip", {7'h00, sk}, {7'h00, sk_o});
      chk("ready", 8'h00, {7'h00, rdy});
      @(posedge clk_i);
      #1;
      chk("ready", 8'h01, {7'h00, rdy});
      chk("squash", {7'h00, sk}, {7'h00, sq});
      if (sk) begin
         // The offered word stays valid until the dummy slot has swallowed it
         @(posedge clk_i);
         #1;
         chk("done", 8'h00, {7'h00, dn});
      end
      chk("working", rw, wr);
      chk("carry", {7'h00, rc}, {7'h00, fl.carry});
      chk("zero", {7'h00, rz}, {7'h00, fl.zero});
      chk("flags", {2'b00, rc, rv, rz, rh, rs, rcz}, {2'b00, fl});
      for (int j = 0; j < 4; j++) begin
         chk("memory", rm[j], i_rsss_mem_model.mem_ff[j]);
      end
   endtask : run
   initial begin
      v = 1'b0;
      op = OP_NONE;
      bs = 3'h0;
      ad = 8'h00;
      rw = WORK_RST;
      rc = 1'b0;
      rz = 1'b0;
      rv = 1'b0;
      rh = 1'b0;
      rs = 1'b0;
      rcz = 1'b0;
      for (int i = 0; i < 256; i++) rm[i] = 8'(i - 2);
      repeat (5) @(posedge clk_i);
      #1;
      reset_i = 1'b0;
      for (int i = 0; i < 11; i++) run(rsss_op_t'(4'(i)), 8'((i + 3) % 4), 3'(i));
      $display("test directed done");
      repeat (300) run(rsss_op_t'(4'(rnd() % 11)), 8'(rnd() % 4), 3'(rnd()));
      $display("test random done");
      give_verdict();
   end
   // Budget is about five times the worst case of three cycles per instruction
   initial begin
      #40000;
      num_errors++;
      give_verdict();
   end
endmodule : testbench
